// ---- rtl/anc_pkg.sv ----
// analogue node configuration bank: offsets, field positions, reset values, carrier types
// assumes the configuration transport delivers one decoded register request per cycle
package anc_pkg;
    localparam logic [7:0] ANC_OFF_IDENT = 8'h00;
    localparam logic [7:0] ANC_OFF_SETUP = 8'h04;
    localparam logic [7:0] ANC_OFF_NODE = 8'h05;
    localparam logic [7:0] ANC_OFF_RSTCTL = 8'h50;
    localparam logic [7:0] ANC_OFF_OSCFREQ = 8'h51;
    localparam logic [7:0] ANC_OFF_LINK = 8'h80;
    localparam logic [7:0] ANC_OFF_WDT = 8'hd6;
    localparam logic [7:0] ANC_OFF_WDKILL = 8'hd7;

    localparam int ANC_IDENT_OSC_BIT = 16;
    localparam int ANC_SETUP_LOCK_BIT = 31;
    localparam int ANC_SETUP_HDR_BIT = 0;
    localparam int ANC_RST_SYS_BIT = 0;
    localparam int ANC_RST_TILE_BIT = 1;
    localparam int ANC_RST_USBEN_BIT = 2;
    localparam int ANC_RST_USBACC_BIT = 3;
    localparam int ANC_RST_MODE_LO = 16;
    localparam int ANC_RST_TRI_BIT = 24;

    localparam logic [31:0] ANC_SETUP_MASK = 32'h8000_0001;
    localparam logic [31:0] ANC_NODE_MASK = 32'h0000_ffff;
    localparam logic [31:0] ANC_RSTCTL_RW_MASK = 32'h0103_000c;
    localparam logic [31:0] ANC_SETUP_RESET = 32'h0000_0000;
    localparam logic [31:0] ANC_NODE_RESET = 32'h0000_0000;
    localparam logic [31:0] ANC_RSTCTL_RESET = 32'h0000_0000;

    localparam int ANC_SYS_RESET_CYCLES = 524288;
    localparam int ANC_TILE_RESET_CYCLES = 16;

    typedef struct packed {
        logic valid;
        logic write;
        logic want_reply;
        logic [7:0] addr;
        logic [31:0] wdata;
    } anc_req_t;

    typedef struct packed {
        logic valid;
        logic ack;
        logic [31:0] rdata;
    } anc_rsp_t;
endpackage

// ---- rtl/anc_sync.sv ----
// two-flop synchroniser for a level from outside the clock domain
// assumes nothing reads the first stage
`timescale 1ns/1ps
module anc_sync
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // level
    input wire logic din,
    output logic dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    always_comb
    begin
        next_stage1 = din;
        next_dout = stage1;
        if (!rstn)
        begin
            next_stage1 = 1'b0;
            next_dout = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        stage1 <= next_stage1;
        dout <= next_dout;
    end
endmodule

// ---- rtl/anc_reset_timer.sv ----
// down counter that holds a reset output for a fixed number of cycles
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
module anc_reset_timer #(
    parameter int CYCLES = 524288,
    parameter int WIDTH = 20
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // trigger and hold
    input wire logic start,
    output logic active
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic next_active;

    always_comb
    begin
        next_count = count;
        next_active = active;
        if (start)
        begin
            next_count = WIDTH'(CYCLES - 1);
            next_active = 1'b1;
        end
        else if (active)
        begin
            if (count == '0)
                next_active = 1'b0;
            else
                next_count = count - 1'b1;
        end
        if (!rstn)
        begin
            next_count = '0;
            next_active = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        count <= next_count;
        active <= next_active;
    end
endmodule

// ---- rtl/anc_regs.sv ----
// analogue node configuration register bank with reset sequencing
// assumes requests are decoded configuration packets on clk; pins pass through anc_sync
// Operation
// R1: registers change only through configuration read and write requests to the node; a system reset also clears setup, node number and reset control
// R2: identification word: chip id 31:24, revision 15:8, version 7:0, read only
// R3: identification bit 16 shows oscillator select pin caught at power-up
// R4: lock bit 31 of node setup blocks later setup and link writes
// R5: node setup bit 0 picks one-byte or three-byte headers, resets to zero
// R6: node number holds 16 writable bits, resets to zero
// R7: two reset scopes: whole system, or processor tiles only
// R8: system reset from pin, brown-out, watchdog; tile reset from sleep, clock change
// R9: system reset lasts 524,288 oscillator cycles from an internal counter
// R10: reset length is a cycle count so it scales with the oscillator
// R11: writing bit 1 starts a tile reset; bit self clears
// R12: writing bit 0 starts a system reset; bit self clears
// R13: reset control write with either reset bit sends no response
// R14: bit 2 enables usb block; clearing resets usb registers
// R15: bit 3 gates usb register access, resets to zero
// R16: bits 17:16 drive mode pins; bit 24 tristates them
// R17: reserved bits read zero and ignore writes
`timescale 1ns/1ps
module anc_regs #(
    parameter logic [7:0] CHIP_ID = 8'h5a,
    parameter logic [7:0] REVISION = 8'h11,
    parameter logic [7:0] VERSION = 8'h22,
    parameter int SYS_RESET_CYCLES = anc_pkg::ANC_SYS_RESET_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // configuration packets
    input wire anc_pkg::anc_req_t req,
    output anc_pkg::anc_rsp_t rsp,
    // reset sources from pins and neighbouring blocks, and the oscillator select pin
    input wire logic ext_reset_n,
    input wire logic brownout,
    input wire logic watchdog_expired,
    input wire logic sleep_entry,
    input wire logic clock_source_change,
    input wire logic oscillator_select_pin,
    // reset outputs
    output logic system_reset,
    output logic processor_tile_reset,
    // usb peripheral control
    output logic usb_enable,
    output logic usb_reg_reset,
    output logic usb_access_enable,
    // node configuration
    output logic one_byte_headers,
    output logic [15:0] node_number_out,
    output logic link_write_en,
    // processor mode pins
    output logic [1:0] mode_pin_out,
    output logic [1:0] mode_pin_oe_n
);
    import anc_pkg::*;

    localparam int TILE_CYCLES = ANC_TILE_RESET_CYCLES;

    logic ext_reset_s;
    logic brownout_s;
    logic watchdog_s;
    logic sleep_s;
    logic clkchg_s;
    logic osc_sel_s;

    logic [31:0] node_setup;
    logic [31:0] node_number;
    logic [31:0] rst_ctl;
    logic osc_bit;
    logic [2:0] osc_settle;
    logic sys_kick;
    logic tile_kick;
    logic sys_active;
    logic tile_active;

    logic [31:0] next_node_setup;
    logic [31:0] next_node_number;
    logic [31:0] next_rst_ctl;
    logic next_osc_bit;
    logic [2:0] next_osc_settle;
    logic next_sys_kick;
    logic next_tile_kick;
    anc_rsp_t next_rsp;
    logic next_system_reset;
    logic next_processor_tile_reset;
    logic next_usb_enable;
    logic next_usb_reg_reset;
    logic next_usb_access_enable;
    logic next_one_byte_headers;
    logic [15:0] next_node_number_out;
    logic next_link_write_en;
    logic [1:0] next_mode_pin_out;
    logic [1:0] next_mode_pin_oe_n;

    logic wr_setup;
    logic wr_node;
    logic wr_rst;
    logic reset_write;
    logic [31:0] ident;
    logic [31:0] rdata;
    logic known;

    function automatic logic hit(input anc_req_t r, input logic [7:0] off);
        hit = r.valid && (r.addr == off);
    endfunction

    // inverted so the synchroniser's cleared state means no reset request
    anc_sync u_sync_rst (.clk(clk), .rstn(rstn), .din(!ext_reset_n), .dout(ext_reset_s));
    anc_sync u_sync_bo (.clk(clk), .rstn(rstn), .din(brownout), .dout(brownout_s));
    anc_sync u_sync_wd (.clk(clk), .rstn(rstn), .din(watchdog_expired), .dout(watchdog_s));
    anc_sync u_sync_sl (.clk(clk), .rstn(rstn), .din(sleep_entry), .dout(sleep_s));
    anc_sync u_sync_cc (.clk(clk), .rstn(rstn), .din(clock_source_change), .dout(clkchg_s));
    anc_sync u_sync_osc (.clk(clk), .rstn(rstn), .din(oscillator_select_pin), .dout(osc_sel_s));

    // system hold counts oscillator cycles, so its length scales with the clock
    anc_reset_timer #(.CYCLES(SYS_RESET_CYCLES), .WIDTH(20)) u_sys_timer // R9 R10
    (
        .clk(clk),
        .rstn(rstn),
        .start(sys_kick),
        .active(sys_active)
    );

    anc_reset_timer #(.CYCLES(TILE_CYCLES), .WIDTH(5)) u_tile_timer
    (
        .clk(clk),
        .rstn(rstn),
        .start(tile_kick),
        .active(tile_active)
    );

    always_comb
    begin
        wr_setup = hit(req, ANC_OFF_SETUP) && req.write && !node_setup[ANC_SETUP_LOCK_BIT]; // R1 R4
        wr_node = hit(req, ANC_OFF_NODE) && req.write; // R1
        wr_rst = hit(req, ANC_OFF_RSTCTL) && req.write; // R1
        reset_write = wr_rst && (req.wdata[ANC_RST_SYS_BIT] || req.wdata[ANC_RST_TILE_BIT]);
        ident = {CHIP_ID, 7'h00, osc_bit, REVISION, VERSION}; // R2 R3 R17
        known = 1'b1;
        case (req.addr)
            ANC_OFF_IDENT: rdata = ident;
            ANC_OFF_SETUP: rdata = node_setup;
            ANC_OFF_NODE: rdata = node_number;
            ANC_OFF_RSTCTL: rdata = rst_ctl; // R11 R12
            default:
            begin
                rdata = 32'h0000_0000;
                known = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        next_node_setup = node_setup;
        next_node_number = node_number;
        next_rst_ctl = rst_ctl;
        if (wr_setup)
            next_node_setup = req.wdata & ANC_SETUP_MASK; // R5 R17
        if (wr_node)
            next_node_number = req.wdata & ANC_NODE_MASK; // R6 R17
        if (wr_rst)
            next_rst_ctl = req.wdata & ANC_RSTCTL_RW_MASK; // R11 R12 R17
        // a system reset returns the control registers to their reset values
        if (sys_active)
        begin
            next_node_setup = ANC_SETUP_RESET;
            next_node_number = ANC_NODE_RESET;
            next_rst_ctl = ANC_RSTCTL_RESET;
        end
        // the synchroniser needs two edges to fill, so the pin is caught on the third
        next_osc_settle = {osc_settle[1:0], 1'b1};
        next_osc_bit = osc_settle[2] ? osc_bit : osc_sel_s; // R3
        next_sys_kick = (wr_rst && req.wdata[ANC_RST_SYS_BIT]) || ext_reset_s
            || brownout_s || watchdog_s; // R8 R12 R7
        next_tile_kick = (wr_rst && req.wdata[ANC_RST_TILE_BIT]) || sleep_s || clkchg_s; // R8 R11 R7
        next_rsp.valid = req.valid && !req.write || (req.valid && req.want_reply && !reset_write); // R13
        next_rsp.ack = known;
        next_rsp.rdata = req.write ? 32'h0000_0000 : rdata;
        next_system_reset = sys_active; // R7
        next_processor_tile_reset = tile_active || sys_active; // R7
        next_usb_enable = next_rst_ctl[ANC_RST_USBEN_BIT]; // R14
        next_usb_reg_reset = !next_rst_ctl[ANC_RST_USBEN_BIT]; // R14
        next_usb_access_enable = next_rst_ctl[ANC_RST_USBACC_BIT]; // R15
        next_one_byte_headers = next_node_setup[ANC_SETUP_HDR_BIT]; // R5
        next_node_number_out = next_node_number[15:0];
        next_link_write_en = !next_node_setup[ANC_SETUP_LOCK_BIT]; // R4
        next_mode_pin_out = next_rst_ctl[ANC_RST_MODE_LO +: 2]; // R16
        next_mode_pin_oe_n = {2{next_rst_ctl[ANC_RST_TRI_BIT]}}; // R16
        if (!rstn)
        begin
            next_node_setup = ANC_SETUP_RESET;
            next_node_number = ANC_NODE_RESET;
            next_rst_ctl = ANC_RSTCTL_RESET;
            next_osc_bit = 1'b0;
            next_osc_settle = 3'h0;
            next_sys_kick = 1'b0;
            next_tile_kick = 1'b0;
            next_rsp = '0;
            next_system_reset = 1'b0;
            next_processor_tile_reset = 1'b0;
            next_usb_enable = 1'b0;
            next_usb_reg_reset = 1'b1;
            next_usb_access_enable = 1'b0;
            next_one_byte_headers = 1'b0;
            next_node_number_out = 16'h0000;
            next_link_write_en = 1'b1;
            next_mode_pin_out = 2'h0;
            next_mode_pin_oe_n = 2'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        node_setup <= next_node_setup;
        node_number <= next_node_number;
        rst_ctl <= next_rst_ctl;
        osc_bit <= next_osc_bit;
        osc_settle <= next_osc_settle;
        sys_kick <= next_sys_kick;
        tile_kick <= next_tile_kick;
        rsp <= next_rsp;
        system_reset <= next_system_reset;
        processor_tile_reset <= next_processor_tile_reset;
        usb_enable <= next_usb_enable;
        usb_reg_reset <= next_usb_reg_reset;
        usb_access_enable <= next_usb_access_enable;
        one_byte_headers <= next_one_byte_headers;
        node_number_out <= next_node_number_out;
        link_write_en <= next_link_write_en;
        mode_pin_out <= next_mode_pin_out;
        mode_pin_oe_n <= next_mode_pin_oe_n;
    end

    property p_lock_holds;
        @(posedge clk) disable iff (!rstn)
        (node_setup[31] && !sys_active) |=> node_setup[31];
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("lock bit dropped"); // R4

    property p_locked_write_ignored;
        @(posedge clk) disable iff (!rstn)
        (node_setup[31] && !sys_active && hit(req, ANC_OFF_SETUP) && req.write) |=> $stable(node_setup);
    endproperty
    a_locked_write_ignored: assert property (p_locked_write_ignored) else $error("locked setup changed"); // R4

    property p_no_reply_on_reset;
        @(posedge clk) disable iff (!rstn)
        reset_write |=> !rsp.valid;
    endproperty
    a_no_reply_on_reset: assert property (p_no_reply_on_reset) else $error("reply after reset write"); // R13

    property p_ident_fields;
        @(posedge clk) disable iff (!rstn)
        (req.valid && !req.write && req.addr == ANC_OFF_IDENT) |=>
            rsp.rdata[31:24] == CHIP_ID && rsp.rdata[15:8] == REVISION && rsp.rdata[23:17] == 7'h00;
    endproperty
    a_ident_fields: assert property (p_ident_fields) else $error("bad identification word"); // R2

    property p_self_clear;
        @(posedge clk) disable iff (!rstn)
        1'b1 |-> rst_ctl[1:0] == 2'h0 && node_number[31:16] == 16'h0000;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("reset bits or reserved bits stored"); // R11 R12 R17

    property p_sys_start;
        @(posedge clk) disable iff (!rstn)
        (wr_rst && req.wdata[0]) |-> ##3 system_reset;
    endproperty
    a_sys_start: assert property (p_sys_start) else $error("system reset not raised"); // R12

    property p_tile_start;
        @(posedge clk) disable iff (!rstn)
        (wr_rst && req.wdata[1]) |-> ##3 processor_tile_reset;
    endproperty
    a_tile_start: assert property (p_tile_start) else $error("tile reset not raised"); // R11

    property p_mode_pins;
        @(posedge clk) disable iff (!rstn)
        1'b1 |-> mode_pin_out == rst_ctl[17:16] && mode_pin_oe_n == {2{rst_ctl[24]}};
    endproperty
    a_mode_pins: assert property (p_mode_pins) else $error("mode pins disagree"); // R16

    property p_usb_gate;
        @(posedge clk) disable iff (!rstn)
        1'b1 |-> usb_access_enable == rst_ctl[3] && usb_reg_reset == !rst_ctl[2];
    endproperty
    a_usb_gate: assert property (p_usb_gate) else $error("usb control disagrees"); // R14 R15

    property p_sys_long;
        @(posedge clk) disable iff (!rstn)
        $rose(sys_active) |=> sys_active [*8];
    endproperty
    a_sys_long: assert property (p_sys_long) else $error("system reset too short"); // R9

    property p_osc_frozen;
        @(posedge clk) disable iff (!rstn)
        osc_settle[2] |=> $stable(osc_bit);
    endproperty
    a_osc_frozen: assert property (p_osc_frozen) else $error("oscillator bit changed after capture"); // R3

    c_sys: cover property (@(posedge clk) disable iff (!rstn) $rose(system_reset));
    c_tile: cover property (@(posedge clk) disable iff (!rstn) $rose(processor_tile_reset) && !system_reset);
    c_lock: cover property (@(posedge clk) disable iff (!rstn) $rose(node_setup[31]));
    c_read: cover property (@(posedge clk) disable iff (!rstn) rsp.valid && rsp.ack && !reset_write);
endmodule

// ---- sim/anc_cfg_master.sv ----
// behavioural configuration master that issues read and write packets to the node
// assumes the bank takes a request on the rising edge and answers in the following cycle
`timescale 1ns/1ps
module anc_cfg_master
(
    // clock
    input wire logic clk,
    // configuration packets
    output anc_pkg::anc_req_t req,
    input wire anc_pkg::anc_rsp_t rsp
);
    import anc_pkg::*;

    initial req = '0;

    // one packet per call; the answer stands for the one cycle after the request edge
    task automatic xfer(input logic wr, input logic want, input logic [7:0] a, input logic [31:0] d,
                        output logic got, output logic ack, output logic [31:0] rd);
        got = 1'b0;
        ack = 1'b0;
        rd = 32'h0;
        @(negedge clk);
        req <= '{valid: 1'b1, write: wr, want_reply: want, addr: a, wdata: d};
        @(negedge clk);
        // released lines show the inverse so a stale value is never mistaken for a live one
        req <= '{valid: 1'b0, write: ~wr, want_reply: ~want, addr: ~a, wdata: ~d};
        if (rsp.valid === 1'b1)
        begin
            got = 1'b1;
            ack = rsp.ack;
            rd = rsp.rdata;
        end
        @(negedge clk);
    endtask
endmodule

// ---- sim/tb.sv ----
// self-checking testbench for the analogue node configuration bank
// assumes anc_cfg_master issues packets; the system reset count is shortened to 64
`timescale 1ns/1ps
module tb;
    import anc_pkg::*;

    localparam int SYS_CYC = 64;
    // identity values are arbitrary
    localparam logic [7:0] CHIP = 8'h3c;
    localparam logic [7:0] REV = 8'h07;
    localparam logic [7:0] VER = 8'h01;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    anc_req_t req;
    anc_rsp_t rsp;
    logic ext_reset_n = 1'b1;
    logic brownout = 1'b0;
    logic watchdog_expired = 1'b0;
    logic sleep_entry = 1'b0;
    logic clock_source_change = 1'b0;
    logic oscillator_select_pin = 1'b1;
    logic system_reset;
    logic processor_tile_reset;
    logic usb_enable;
    logic usb_reg_reset;
    logic usb_access_enable;
    logic one_byte_headers;
    logic [15:0] node_number_out;
    logic link_write_en;
    logic [1:0] mode_pin_out;
    logic [1:0] mode_pin_oe_n;
    int num_errors = 0;
    int total_checks = 0;
    int n;
    logic oth;

    always #4 clk = ~clk;

    anc_cfg_master m (.clk(clk), .req(req), .rsp(rsp));

    anc_regs #(.CHIP_ID(CHIP), .REVISION(REV), .VERSION(VER), .SYS_RESET_CYCLES(SYS_CYC)) uut (
        .clk(clk), .rstn(rstn), .req(req), .rsp(rsp), .ext_reset_n(ext_reset_n), .brownout(brownout),
        .watchdog_expired(watchdog_expired), .sleep_entry(sleep_entry),
        .clock_source_change(clock_source_change), .oscillator_select_pin(oscillator_select_pin),
        .system_reset(system_reset), .processor_tile_reset(processor_tile_reset), .usb_enable(usb_enable),
        .usb_reg_reset(usb_reg_reset), .usb_access_enable(usb_access_enable),
        .one_byte_headers(one_byte_headers), .node_number_out(node_number_out),
        .link_write_en(link_write_en), .mode_pin_out(mode_pin_out), .mode_pin_oe_n(mode_pin_oe_n));

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic exp_ack, input logic [31:0] exp);
        logic got;
        logic ack;
        logic [31:0] d;
        m.xfer(1'b0, 1'b1, a, 32'h0, got, ack, d);
        chk({31'h0, got}, 32'h1);
        chk({31'h0, ack}, {31'h0, exp_ack});
        if (exp_ack)
            chk(d, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic want, input logic exp_got);
        logic got;
        logic ack;
        logic [31:0] d;
        m.xfer(1'b1, want, a, v, got, ack, d);
        chk({31'h0, got}, {31'h0, exp_got});
    endtask

    // waits for one reset output to rise, counts its high cycles, notes whether the other rose too
    task automatic hold_len(input logic sys, output int len, output logic other);
        int w;
        w = 0;
        len = 0;
        other = 1'b0;
        while ((sys ? system_reset : processor_tile_reset) !== 1'b1 && w < 20)
        begin
            @(negedge clk);
            w++;
        end
        while ((sys ? system_reset : processor_tile_reset) === 1'b1 && len < 200)
        begin
            other = other | (sys ? processor_tile_reset : system_reset);
            @(negedge clk);
            len++;
        end
        if (w == 20 || len == 200)
        begin
            chk(32'h1, 32'h0);
            complete_run();
        end
    endtask

    function automatic logic [31:0] pins();
        return {25'h0, mode_pin_oe_n, mode_pin_out, usb_access_enable, usb_enable, usb_reg_reset};
    endfunction

    initial
    begin
        repeat (2) @(negedge clk);
        rstn <= 1'b1;
        repeat (4) @(negedge clk);
        rd(ANC_OFF_IDENT, 1'b1, {CHIP, 7'h0, 1'b1, REV, VER});
        wr(ANC_OFF_IDENT, 32'hffff_ffff, 1'b1, 1'b1);
        rd(ANC_OFF_IDENT, 1'b1, {CHIP, 7'h0, 1'b1, REV, VER});
        rd(ANC_OFF_SETUP, 1'b1, 32'h0);
        rd(ANC_OFF_NODE, 1'b1, 32'h0);
        rd(ANC_OFF_RSTCTL, 1'b1, 32'h0);
        chk(pins(), 32'h1);
        wr(ANC_OFF_SETUP, 32'h7fff_ffff, 1'b1, 1'b1);
        rd(ANC_OFF_SETUP, 1'b1, 32'h1);
        chk({31'h0, one_byte_headers}, 32'h1);
        wr(ANC_OFF_NODE, 32'hffff_a5c3, 1'b0, 1'b0);
        rd(ANC_OFF_NODE, 1'b1, 32'h0000_a5c3);
        chk({16'h0, node_number_out}, 32'ha5c3);
        wr(ANC_OFF_RSTCTL, 32'hffff_fffc, 1'b1, 1'b1);
        rd(ANC_OFF_RSTCTL, 1'b1, 32'h0103_000c);
        chk(pins(), 32'h7e);
        wr(ANC_OFF_RSTCTL, 32'h0002_0000, 1'b1, 1'b1);
        chk(pins(), 32'h11);
        rd(ANC_OFF_OSCFREQ, 1'b0, 32'h0);
        wr(ANC_OFF_SETUP, 32'h8000_0000, 1'b1, 1'b1);
        chk({31'h0, link_write_en}, 32'h0);
        wr(ANC_OFF_SETUP, 32'h0000_0001, 1'b1, 1'b1);
        rd(ANC_OFF_SETUP, 1'b1, 32'h8000_0000);
        wr(ANC_OFF_RSTCTL, 32'h0000_0006, 1'b1, 1'b0);
        hold_len(1'b0, n, oth);
        chk(n, ANC_TILE_RESET_CYCLES);
        chk({31'h0, oth}, 32'h0);
        rd(ANC_OFF_RSTCTL, 1'b1, 32'h0000_0004);
        wr(ANC_OFF_RSTCTL, 32'h0000_0001, 1'b1, 1'b0);
        hold_len(1'b1, n, oth);
        chk(n, SYS_CYC);
        chk({31'h0, oth}, 32'h1);
        rd(ANC_OFF_SETUP, 1'b1, 32'h0);
        rd(ANC_OFF_NODE, 1'b1, 32'h0);
        chk({31'h0, link_write_en}, 32'h1);
        for (int s = 0; s < 5; s++)
        begin
            ext_reset_n <= (s != 0);
            brownout <= (s == 1);
            watchdog_expired <= (s == 2);
            sleep_entry <= (s == 3);
            clock_source_change <= (s == 4);
            repeat (4) @(negedge clk);
            ext_reset_n <= 1'b1;
            brownout <= 1'b0;
            watchdog_expired <= 1'b0;
            sleep_entry <= 1'b0;
            clock_source_change <= 1'b0;
            hold_len(s < 3, n, oth);
            chk({31'h0, oth}, {31'h0, s < 3});
        end
        complete_run();
    end
endmodule
